// ---- logic/audio_modulated_pwm_pair.sv ----
/*
 Two pulse-width generators, each fed by a four-input audio mixer or a fixed level,
 with an Avalon-MM register slave. Assumes samples arrive on the core clock domain
 and an outside pin mux routes pwm_out to the pins.
*/
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/10ps
module audio_modulated_pwm_pair #(
    parameter int NUM_SRC  = 8,
    parameter int MIX_COST = 2048
) (
    input  logic                                ref_clk,
    input  logic                                sys_rst,
    input  logic [15:0]                         address,
    input  logic                                read,
    input  logic                                write,
    input  logic [31:0]                         writedata,
    input  logic [3:0]                          byteenable,
    output logic [31:0]                         readdata,
    output logic                                waitrequest,
    input  pwm_pair_pkg::sample_t [NUM_SRC-1:0] src_samples,
    output logic [1:0]                          pwm_out
);
    import pwm_pair_pkg::*;

    bus_state_t        bus_ph_r, bus_ph_nxt;
    logic [15:0]       drive_ctrl_r, drive_ctrl_nxt;
    logic [1:0][9:0]   level_r, level_nxt;
    logic [2:0][15:0]  rate_r, rate_nxt;
    logic [31:0]       readdata_r, readdata_nxt;
    logic              wait_r, wait_nxt;
    logic [15:0]       old_word_r, old_word_nxt;
    logic [7:0]        src_nz_r, src_nz_nxt;
    logic [1:0]        active_r, active_nxt;
    logic [1:0]        fail_r, fail_nxt;
    logic [15:0]       idx, cur_word, new_word, rate_word, mem_rdata;
    logic [3:0]        mix_idx, mem_raddr;
    logic              in_mix, bus_req, bus_steal, commit, fits, mem_we;
    logic [31:0]       need, avail;
    gen_cfg_t [1:0]    cfg;

    // register decode; the mixer span is word indices 0x640..0x64F
    assign idx       = {2'b00, address[15:2]};
    assign in_mix    = (idx >= IDX_MIX_FIRST) && (idx <= IDX_MIX_LAST);  // RQ18
    assign mix_idx   = idx[3:0];
    assign bus_req   = read | write;
    assign bus_steal = (bus_ph_r == BUS_IDLE) && bus_req;
    assign commit    = (bus_ph_r == BUS_ANSWER) && write;
    assign new_word  = merge16(old_word_r, writedata[15:0], byteenable[1:0]);

    // per-generator view of the control registers
    always_comb
    begin
        for (int g = 0; g < 2; g++)
        begin
            cfg[g].enable   = drive_ctrl_r[ENA_LSB + g];
            cfg[g].override = drive_ctrl_r[OVD_LSB + g];
            cfg[g].level    = level_r[g];
        end
    end

    // selected sample-rate word; reserved codes fall back to rate one
    always_comb
    begin
        case (drive_ctrl_r[RATE_MSB:RATE_LSB])  // RQ20
            RATE_CODE_TWO:   rate_word = rate_r[1];
            RATE_CODE_THREE: rate_word = rate_r[2];
            default:         rate_word = rate_r[0];
        endcase
    end

    // cycle budget: one more mixer must fit within the core cycles of one sample
    assign avail = 32'(rate_word[9:0]) * 32'(CYC_PER_BASE);
    assign need  = (32'(active_r[0]) + 32'(active_r[1]) + 32'd1) * 32'(MIX_COST);
    assign fits  = need <= avail;  // RQ16

    // readable view of the addressed word
    always_comb
    begin
        cur_word = 16'h0000;
        if (in_mix)
            cur_word = mem_rdata;
        else if (idx == IDX_DRIVE_CTRL)
            cur_word = drive_ctrl_r;
        else if (idx == IDX_LEVEL_ONE)
            cur_word = {6'h00, level_r[0]};
        else if (idx == IDX_LEVEL_TWO)
            cur_word = {6'h00, level_r[1]};
        else if (idx == IDX_MIX_STATUS)
            cur_word = {12'h000, fail_r, active_r};  // RQ17
        else if (idx >= IDX_RATE_ONE && idx <= IDX_RATE_THREE)
            cur_word = rate_r[2'(idx - IDX_RATE_ONE)];
    end

    // bus sequence: fetch old word, answer one cycle, commit write on that edge
    always_comb
    begin
        bus_ph_nxt     = bus_ph_r;
        drive_ctrl_nxt = drive_ctrl_r;
        level_nxt      = level_r;
        rate_nxt       = rate_r;
        readdata_nxt   = readdata_r;
        wait_nxt       = wait_r;
        old_word_nxt   = old_word_r;
        src_nz_nxt     = src_nz_r;
        active_nxt     = active_r;
        fail_nxt       = fail_r;
        mem_we         = 1'b0;
        case (bus_ph_r)
            BUS_IDLE:
            begin
                if (bus_req)
                    bus_ph_nxt = BUS_FETCH;
            end
            BUS_FETCH:
            begin
                old_word_nxt = cur_word;
                readdata_nxt = read ? {16'h0000, cur_word} : 32'h0000_0000;
                wait_nxt     = 1'b0;
                bus_ph_nxt   = BUS_ANSWER;
            end
            BUS_ANSWER:
            begin
                wait_nxt   = 1'b1;
                bus_ph_nxt = BUS_IDLE;
                if (write)
                begin
                    if (idx == IDX_DRIVE_CTRL)
                        drive_ctrl_nxt = new_word & DRIVE_CTRL_MASK;  // RQ11 RQ20
                    else if (idx == IDX_LEVEL_ONE)
                        level_nxt[0] = new_word[9:0];  // RQ14
                    else if (idx == IDX_LEVEL_TWO)
                        level_nxt[1] = new_word[9:0];
                    else if (idx >= IDX_RATE_ONE && idx <= IDX_RATE_THREE)
                        rate_nxt[2'(idx - IDX_RATE_ONE)] = new_word & RATE_REG_MASK;
                    else if (in_mix)
                    begin
                        mem_we = 1'b1;
                        if (!mix_idx[0])
                        begin
                            src_nz_nxt[mix_idx[3:1]] = (new_word[7:0] != SRC_NONE);
                            // an enable attempt on an idle mixer; others stay as they are
                            if (new_word[7:0] != SRC_NONE && !active_r[mix_idx[3]])
                            begin
                                active_nxt[mix_idx[3]] = fits;  // RQ16
                                fail_nxt[mix_idx[3]]   = !fits;  // RQ17
                            end
                        end
                    end
                end
            end
            default: bus_ph_nxt = BUS_IDLE;
        endcase
        // a mixer with every source cleared is off and its failure forgotten
        for (int m = 0; m < 2; m++)
        begin
            if (src_nz_nxt[m*4 +: 4] == 4'h0)
            begin
                active_nxt[m] = 1'b0;
                fail_nxt[m]   = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bus_ph_r     <= BUS_IDLE;
            drive_ctrl_r <= DRIVE_CTRL_RST;  // RQ9 RQ10
            level_r      <= {LEVEL_RST, LEVEL_RST};  // RQ14
            rate_r       <= {RATE_REG_RST, RATE_REG_RST, RATE_REG_RST};
            readdata_r   <= 32'h0000_0000;
            wait_r       <= 1'b1;
            old_word_r   <= 16'h0000;
            src_nz_r     <= 8'h00;
            active_r     <= 2'b00;
            fail_r       <= 2'b00;
        end
        else
        begin
            bus_ph_r     <= bus_ph_nxt;
            drive_ctrl_r <= drive_ctrl_nxt;
            level_r      <= level_nxt;
            rate_r       <= rate_nxt;
            readdata_r   <= readdata_nxt;
            wait_r       <= wait_nxt;
            old_word_r   <= old_word_nxt;
            src_nz_r     <= src_nz_nxt;
            active_r     <= active_nxt;
            fail_r       <= fail_nxt;
        end
    end

    mixer_word_mem #(.WIDTH(16), .DEPTH(16), .AW(4)) u_mix_mem (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .wr_en   (mem_we),
        .wr_addr (mix_idx),
        .wr_data (new_word),
        .rd_addr (mem_raddr),
        .rd_data (mem_rdata)
    );

    logic [3:0]              scan_idx_r, scan_idx_nxt, scan_addr_r, scan_addr_nxt;
    logic                    scan_vld_r, scan_vld_nxt;
    logic [7:0]              src_hold_r, src_hold_nxt;
    logic signed [13:0]      acc_r, acc_nxt, sum;
    logic [1:0][9:0]         mix_r, mix_nxt;
    sample_t                 picked;

    // the bus borrows the read port for one cycle; the scan simply waits
    assign mem_raddr = bus_steal ? mix_idx : scan_idx_r;

    // source table holds only external samples, never the generator outputs
    always_comb
    begin
        picked = '0;
        for (int k = 0; k < NUM_SRC; k++)
        begin
            if (src_hold_r == 8'(k + 1))
                picked = src_samples[k];  // RQ4
        end
    end

    // scan all 16 words: source then volume, four inputs per mixer
    always_comb
    begin
        scan_idx_nxt  = bus_steal ? scan_idx_r : scan_idx_r + 4'h1;
        scan_vld_nxt  = !bus_steal;
        scan_addr_nxt = scan_idx_r;
        src_hold_nxt  = src_hold_r;
        acc_nxt       = acc_r;
        mix_nxt       = mix_r;
        sum           = acc_r + mix_term(picked, mem_rdata[7:0]);  // RQ2
        if (scan_vld_r)
        begin
            if (!scan_addr_r[0])
                src_hold_nxt = mem_rdata[7:0];
            else if (scan_addr_r[2:0] == 3'h7)
            begin
                mix_nxt[scan_addr_r[3]] = active_r[scan_addr_r[3]] ? sat10(sum) : 10'h000;
                acc_nxt                 = '0;
            end
            else
                acc_nxt = sum;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            scan_idx_r  <= 4'h0;
            scan_vld_r  <= 1'b0;
            scan_addr_r <= 4'h0;
            src_hold_r  <= 8'h00;
            acc_r       <= '0;
            mix_r       <= '0;
        end
        else
        begin
            scan_idx_r  <= scan_idx_nxt;
            scan_vld_r  <= scan_vld_nxt;
            scan_addr_r <= scan_addr_nxt;
            src_hold_r  <= src_hold_nxt;
            acc_r       <= acc_nxt;
            mix_r       <= mix_nxt;
        end
    end

    logic [31:0]       ph_r, ph_nxt, inc_cur;
    logic              tick_r, tick_nxt, any_en, wrap;
    logic [2:0]        sel_eff;
    logic [11:0]       cnt_r, cnt_nxt, per_r, per_nxt, per_cur;
    logic [1:0][11:0]  high_r, high_nxt;
    logic [1:0]        out_r, out_nxt;

    // reserved clock codes run at the base rate; a faster clock gives more steps
    assign sel_eff = (drive_ctrl_r[CLKSEL_MSB:CLKSEL_LSB] > CLKSEL_24M) ? 3'h0
                   : drive_ctrl_r[CLKSEL_MSB:CLKSEL_LSB];
    assign inc_cur = gen_inc(sel_eff, rate_word[RATE_FAMILY_BIT]);  // RQ11
    assign per_cur = {2'b00, rate_word[9:0]} << sel_eff;  // RQ12 RQ15
    assign any_en  = cfg[0].enable | cfg[1].enable;
    assign wrap    = cnt_r >= per_r - 12'h001;

    // generator tick from a phase accumulator, shared period counter, two compares
    always_comb
    begin
        {tick_nxt, ph_nxt} = any_en ? 33'(ph_r) + 33'(inc_cur) : 33'h0;
        cnt_nxt            = cnt_r;
        per_nxt            = per_r;
        high_nxt           = high_r;
        if (!any_en)
        begin
            cnt_nxt  = 12'h000;
            per_nxt  = per_cur;
            high_nxt = '0;
        end
        else if (tick_r)
        begin
            if (wrap)
            begin
                cnt_nxt = 12'h000;
                per_nxt = per_cur;  // RQ15
                for (int g = 0; g < 2; g++)
                    high_nxt[g] = duty_ticks(cfg[g].override ? cfg[g].level : mix_r[g],
                                             per_cur);  // RQ1 RQ10 RQ21
            end
            else
                cnt_nxt = cnt_r + 12'h001;
        end
        for (int g = 0; g < 2; g++)
            out_nxt[g] = cfg[g].enable && (cnt_r < high_r[g]);  // RQ9
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ph_r   <= 32'h0000_0000;
            tick_r <= 1'b0;
            cnt_r  <= 12'h000;
            per_r  <= 12'h080;
            high_r <= '0;
            out_r  <= 2'b00;
        end
        else
        begin
            ph_r   <= ph_nxt;
            tick_r <= tick_nxt;
            cnt_r  <= cnt_nxt;
            per_r  <= per_nxt;
            high_r <= high_nxt;
            out_r  <= out_nxt;
        end
    end

    // outputs straight from flops; pwm_out goes to the pin mux as is
    assign pwm_out     = out_r;  // RQ3
    assign readdata    = readdata_r;
    assign waitrequest = wait_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_off_stays_low: assert property (!cfg[0].enable |=> !pwm_out[0])  // RQ9
        else $error("disabled generator one drove high");
    a_zero_duty: assert property (tick_r && wrap && any_en && cfg[0].override
        && cfg[0].level == LEVEL_ZERO_DUTY |=> high_r[0] == 12'h000)  // RQ14
        else $error("level 0x200 did not give zero duty");
    a_half_duty: assert property (tick_r && wrap && any_en && cfg[1].override
        && cfg[1].level == LEVEL_HALF_DUTY |=> high_r[1] == (per_r >> 1))  // RQ14
        else $error("level 0x000 did not give half duty");
    a_audio_duty: assert property (tick_r && wrap && any_en && !cfg[0].override
        |=> high_r[0] == duty_ticks($past(mix_r[0]), per_r))  // RQ10
        else $error("audio mode duty does not follow mixer");
    a_period_wrap: assert property (tick_r && wrap && any_en
        |=> cnt_r == 12'h000 && per_r == $past(per_cur))  // RQ15
        else $error("period did not restart at sample boundary");
    a_clock_step: assert property (any_en && $past(any_en)
        |-> ph_r == 32'($past(ph_r) + $past(inc_cur)))  // RQ11
        else $error("generator tick rate wrong for clock select");
    a_refused_keep: assert property (commit && in_mix && !mix_idx[0]
        && new_word[7:0] != SRC_NONE && !fits |=> active_r == $past(active_r))  // RQ16
        else $error("refused enable disturbed mixer state");
    a_refused_flag: assert property (commit && in_mix && !mix_idx[0] && !fits  // RQ17
        && new_word[7:0] != SRC_NONE && !active_r[mix_idx[3]] |=> fail_r[$past(mix_idx[3])])
        else $error("failed enable not reported");
    a_status_read: assert property (bus_ph_r == BUS_FETCH && read
        && idx == IDX_MIX_STATUS |=> readdata[1:0] == $past(active_r))  // RQ17
        else $error("status read does not show active mixers");
    a_span_write: assert property (mem_we |-> in_mix && commit)  // RQ18
        else $error("mixer store written outside its span");
    a_bus_timing: assert property (bus_steal |-> waitrequest ##2 !waitrequest ##1 waitrequest)
        else $error("bus answer not two cycles after request");

    c_both_high: cover property (pwm_out[0] && pwm_out[1]);
    c_refused: cover property (fail_r[0]);
    c_mix_write: cover property (commit && in_mix);
    c_audio_period: cover property (tick_r && wrap && any_en && !cfg[0].override);
endmodule

// ---- logic/pwm_pair_pkg.sv ----
/*
 Shared constants, types and helpers for the audio-driven pulse-width pair.
 Assumes a 200 MHz core clock and word-indexed registers on a 32-bit bus.
*/
// Notes on behaviour
// RQ1: two independent generators, duty from audio or from a fixed level
// RQ2: each generator owns a four-input mixer, per-input source and volume
// RQ3: each generator output can drive a general-purpose pin directly
// RQ4: generator outputs are never offered as mixer or processing sources
// RQ5: software picks only sources running at the generator mixer rate
// RQ6: software keeps both enables low while the core clock is off
// RQ7: source selects stay zero until the core clock runs
// RQ8: clear sources, wait 125 us, then change the sample rate select
// RQ9: a generator runs only while its enable is set; enables reset low
// RQ10: override clear uses mixer audio, override set uses fixed level
// RQ11: three-bit clock select: 6.144, 12.288, 24.576 MHz (44.1k family scaled)
// RQ12: higher generator clock gives finer duty resolution
// RQ13: software never picks a generator clock above the core clock
// RQ14: fixed level ten bits two's complement, reset 0x100, 0x000 half, 0x200 none
// RQ15: period equals one sample period of the selected rate
// RQ16: mixer enable refused when core cycles are short; active paths untouched
// RQ17: status bits show which mixers actually became enabled
// RQ18: mixer source and volume words sit at 0x0640 to 0x064F
// RQ19: software inserts rate conversion toward chains at other rates
// RQ20: rate select is bits 14:11, reset 0000, codes 0 to 2 pick rates 1 to 3
// RQ21: mixer output maps linearly onto duty, same coding as fixed level
package pwm_pair_pkg;

    localparam longint CORE_CLK_HZ  = 200_000_000;
    localparam int     CLK_PERIOD_NS = 5;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_DRIVE_CTRL = 16'h0030;
    localparam logic [15:0] IDX_LEVEL_ONE  = 16'h0031;
    localparam logic [15:0] IDX_LEVEL_TWO  = 16'h0032;
    localparam logic [15:0] IDX_MIX_STATUS = 16'h0033;
    localparam logic [15:0] IDX_RATE_ONE   = 16'h0034;
    localparam logic [15:0] IDX_RATE_THREE = 16'h0036;
    localparam logic [15:0] IDX_MIX_FIRST  = 16'h0640;
    localparam logic [15:0] IDX_MIX_LAST   = 16'h064F;

    // drive control fields
    localparam int RATE_MSB    = 14;
    localparam int RATE_LSB    = 11;
    localparam int CLKSEL_MSB  = 10;
    localparam int CLKSEL_LSB  = 8;
    localparam int OVD_LSB     = 4;
    localparam int ENA_LSB     = 0;
    localparam logic [15:0] DRIVE_CTRL_MASK = 16'h7F33;
    localparam logic [15:0] DRIVE_CTRL_RST  = 16'h0000;
    localparam logic [3:0]  RATE_CODE_TWO   = 4'h1;
    localparam logic [3:0]  RATE_CODE_THREE = 4'h2;
    localparam logic [2:0]  CLKSEL_12M      = 3'h1;
    localparam logic [2:0]  CLKSEL_24M      = 3'h2;

    // fixed levels and sample-rate setup words
    localparam logic [9:0]  LEVEL_RST       = 10'h100;
    localparam logic [9:0]  LEVEL_HALF_DUTY = 10'h000;
    localparam logic [9:0]  LEVEL_ZERO_DUTY = 10'h200;
    localparam int          RATE_FAMILY_BIT = 15;
    localparam logic [15:0] RATE_REG_MASK   = 16'h83FF;
    localparam logic [15:0] RATE_REG_RST    = 16'h0080;

    // generator base clock and phase increment per core cycle
    localparam longint GEN_HZ_48 = 6_144_000;
    localparam longint GEN_HZ_44 = 5_644_800;
    localparam logic [31:0] INC_48 = 32'((GEN_HZ_48 << 32) / CORE_CLK_HZ);
    localparam logic [31:0] INC_44 = 32'((GEN_HZ_44 << 32) / CORE_CLK_HZ);
    localparam int CYC_PER_BASE = int'(CORE_CLK_HZ / GEN_HZ_48);

    // mixer words: even index source, odd index volume, unity volume 0x80
    localparam int         VOL_SHIFT = 7;
    localparam logic [7:0] SRC_NONE  = 8'h00;

    typedef logic signed [9:0] sample_t;
    typedef enum logic [1:0] {BUS_IDLE, BUS_FETCH, BUS_ANSWER} bus_state_t;
    typedef struct packed {
        logic       enable;
        logic       override;
        logic [9:0] level;
    } gen_cfg_t;

    function automatic logic [11:0] duty_ticks(input logic [9:0] lvl, input logic [11:0] per);
        logic [21:0] prod;
        prod = 22'({~lvl[9], lvl[8:0]}) * 22'(per);
        return prod[21:10];
    endfunction

    function automatic logic [31:0] gen_inc(input logic [2:0] sel, input logic fam);
        logic [31:0] base;
        base = fam ? INC_44 : INC_48;
        case (sel)
            CLKSEL_12M: return base << 1;
            CLKSEL_24M: return base << 2;
            default:    return base;
        endcase
    endfunction

    function automatic logic signed [13:0] mix_term(input sample_t smp, input logic [7:0] vol);
        logic signed [18:0] prod;
        prod = 19'(smp) * 19'($signed({1'b0, vol}));
        return 14'(prod >>> VOL_SHIFT);
    endfunction

    function automatic logic [9:0] sat10(input logic signed [13:0] v);
        if (v > 14'sd511)
            return 10'h1FF;
        if (v < -14'sd512)
            return 10'h200;
        return v[9:0];
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                            input logic [1:0] be);
        return {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    endfunction

endpackage

// ---- logic/mixer_word_mem.sv ----
/*
 Small word store for mixer source and volume words, registered read port.
 Assumes one writer and one reader on the same clock.
*/
`timescale 1ns/10ps
module mixer_word_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  logic             ref_clk,
    input  logic             sys_rst,
    input  logic             wr_en,
    input  logic [AW-1:0]    wr_addr,
    input  logic [WIDTH-1:0] wr_data,
    input  logic [AW-1:0]    rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [DEPTH-1:0][WIDTH-1:0] mem_r, mem_nxt;
    logic [WIDTH-1:0]            rd_r, rd_nxt;

    // write merge and read fetch
    always_comb
    begin
        mem_nxt = mem_r;
        if (wr_en)
            mem_nxt[wr_addr] = wr_data;
        rd_nxt = mem_r[rd_addr];
    end

    // cleared at reset so every source select starts as "none"
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mem_r <= '0;
            rd_r  <= '0;
        end
        else
        begin
            mem_r <= mem_nxt;
            rd_r  <= rd_nxt;
        end
    end

    assign rd_data = rd_r;
endmodule

// ---- verif/pin_load_model.sv ----
/*
 Load on one generator pin: counts high cycles over one window.
 Assumes the pin is a plain registered level on ref_clk.
*/
`timescale 1ns/10ps
module pin_load_model #(
    parameter int WIN = 4167
) (
    input  wire logic        ref_clk,
    input  wire logic        pin,
    input  wire logic        start,
    output logic             done = 1'b0,
    output logic [15:0]      eighths = 16'h0000
);
    int cnt = 0;
    int hi  = 0;
    // pin sampled directly, no conditioning, as a bare input would see it
    always @(posedge ref_clk)
    begin
        done <= 1'b0;
        if (start)
        begin
            cnt <= WIN;
            hi  <= 0;
        end
        else if (cnt > 0)
        begin
            cnt <= cnt - 1;
            hi  <= hi + int'(pin === 1'b1);
            done <= (cnt == 1);
            eighths <= 16'(((hi + int'(pin === 1'b1)) * 8 + WIN / 2) / WIN);
        end
    end
endmodule

// ---- verif/tb_top.sv ----
/*
 Self-checking bench for the generator pair: registers, duty, mixer refusal.
 Assumes one window equals one period at the reset sample rate.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
    import pwm_pair_pkg::*;
    localparam int WIN = 4167;
    logic          ref_clk = 1'b0;
    logic          sys_rst = 1'b1;
    logic [15:0]   address = 16'h0000;
    logic          read = 1'b0;
    logic          write = 1'b0;
    logic [31:0]   writedata = 32'h0000_0000;
    logic [31:0]   readdata;
    logic          waitrequest;
    sample_t [7:0] src_samples = '0;
    logic [1:0]    pwm_out;
    logic [3:0]    be = 4'hF;
    logic [1:0]    start = 2'b00;
    logic [1:0]    done;
    logic [15:0]   duty0, duty1, got, ev, k;
    logic [31:0]   seed = 32'd89892;
    int            mismatches = 0;
    int            check_count = 0;
    string         nm;
    string         name_q[$];
    logic [15:0]   exp_q[$];

    audio_modulated_pwm_pair #(.NUM_SRC(8), .MIX_COST(4096)) u_dut (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(be), .readdata(readdata),
        .waitrequest(waitrequest), .src_samples(src_samples), .pwm_out(pwm_out));
    pin_load_model #(.WIN(WIN)) u_load_one (.ref_clk(ref_clk), .pin(pwm_out[0]),
        .start(start[0]), .done(done[0]), .eighths(duty0));
    pin_load_model #(.WIN(WIN)) u_load_two (.ref_clk(ref_clk), .pin(pwm_out[1]),
        .start(start[1]), .done(done[1]), .eighths(duty1));

    initial forever #2.5 ref_clk = ~ref_clk;

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task end_of_test();
        if (mismatches == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // request held until the edge that sees waitrequest low
    task bus(input logic we, input logic [15:0] idx, input logic [15:0] wd);
        @(posedge ref_clk);
        read <= ~we;
        write <= we;
        address <= {idx[13:0], 2'b00};
        writedata <= {16'h0000, wd};
        // no cycle limit here: a slave that never answers is caught by the watchdog
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task note(input string n, input logic [15:0] e);
        name_q.push_back(n);
        exp_q.push_back(e);
    endtask

    task rd_chk(input string n, input logic [15:0] idx, input logic [15:0] e);
        note(n, e);
        bus(1'b0, idx, 16'h0000);
    endtask

    // first wait lets a fresh period latch the new duty
    task meas(input int ch, input string n, input logic [15:0] e);
        note(n, e);
        repeat (WIN) @(posedge ref_clk);
        start[ch] <= 1'b1;
        @(posedge ref_clk);
        start <= 2'b00;
        repeat (WIN + 4) @(posedge ref_clk);
    endtask

    // read answers and pin windows never overlap, so one queue serves both
    always @(posedge ref_clk)
        if ((read && waitrequest === 1'b0) || done !== 2'b00)
        begin
            got = done[0] ? duty0 : (done[1] ? duty1 : readdata[15:0]);
            nm = name_q.pop_front();
            ev = exp_q.pop_front();
            `CHK(nm, ev, got)
        end

    initial
    begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd_chk("ctrl_rst", IDX_DRIVE_CTRL, DRIVE_CTRL_RST);
        rd_chk("lvl1_rst", IDX_LEVEL_ONE, 16'h0100);
        rd_chk("lvl2_rst", IDX_LEVEL_TWO, 16'h0100);
        rd_chk("unmapped", 16'h0100, 16'h0000);
        bus(1'b1, IDX_DRIVE_CTRL, 16'hFFFF);
        rd_chk("ctrl_mask", IDX_DRIVE_CTRL, DRIVE_CTRL_MASK);
        be <= 4'h1;
        bus(1'b1, IDX_DRIVE_CTRL, 16'h0000);
        be <= 4'hF;
        rd_chk("ctrl_bytes", IDX_DRIVE_CTRL, DRIVE_CTRL_MASK & 16'hFF00);
        rd_chk("rate3_rst", IDX_RATE_THREE, RATE_REG_RST);
        bus(1'b1, IDX_DRIVE_CTRL, 16'h0011);
        meas(0, "duty_rst", 16'h0006);
        meas(1, "duty_off", 16'h0000);
        bus(1'b1, IDX_LEVEL_ONE, 16'(LEVEL_HALF_DUTY));
        bus(1'b1, IDX_LEVEL_TWO, 16'(LEVEL_HALF_DUTY));
        for (int c = 0; c < 3; c++)
        begin
            bus(1'b1, IDX_DRIVE_CTRL, 16'(c << CLKSEL_LSB) | 16'h0033);
            meas(c % 2, "duty_half", 16'h0004);
        end
        bus(1'b1, IDX_LEVEL_ONE, 16'(LEVEL_ZERO_DUTY));
        meas(0, "duty_zero", 16'h0000);
        seed = xs(seed);
        k = 16'(seed % 6 + 1);
        for (int i = 1; i < 8; i++)
        begin
            seed = xs(seed);
            src_samples[i] <= sample_t'(seed[9:0]);
        end
        src_samples[0] <= sample_t'((k[9:0] << 7) ^ 10'h200);
        bus(1'b1, IDX_MIX_FIRST + 16'h0001, 16'h0080);
        bus(1'b1, IDX_MIX_FIRST, 16'h0001);
        bus(1'b1, IDX_DRIVE_CTRL, 16'h0001);
        rd_chk("mix_on", IDX_MIX_STATUS, 16'h0001);
        meas(0, "duty_audio", k);
        bus(1'b1, IDX_MIX_FIRST + 16'h0008, 16'h0002);
        rd_chk("mix_refused", IDX_MIX_STATUS, 16'h0009);
        meas(0, "duty_kept", k);
        `CHK("queue_left", 16'h0000, 16'(name_q.size()))
        end_of_test();
    end

    initial
    begin
        repeat (90000) @(posedge ref_clk);
        mismatches++;
        end_of_test();
    end
endmodule
